// [verilog/icfu_ctrl.sv]
// Cycle-count and flag-update controller for the 8-bit core.
// Assumes one classified instruction per request, offered while ready is high.
`timescale 1ns/1ps

module icfu_ctrl
    import icfu_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          instr_valid,
    input  wire icfu_instr_s   instr,
    input  wire logic          irq_entry,
    output logic               instr_ready_ff,
    output icfu_status_s       status_ff,
    output logic               gie_ff
);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic [3:0] flag_mask(input icfu_opc_e opc);
        unique case (opc)
            OPC_ARITH, OPC_SKIP_CMP: flag_mask = FMASK_ALL;  // [RQ5]
            OPC_LOGIC_Z:             flag_mask = FMASK_Z;    // [RQ6]
            OPC_CARRY:               flag_mask = FMASK_C;    // [RQ7]
            OPC_RESTORE:             flag_mask = FMASK_ALL;  // [RQ7]
            default:                 flag_mask = FMASK_NONE; // [RQ6] [RQ7]
        endcase
    endfunction

    function automatic logic is_bit_op(input icfu_opc_e opc);
        is_bit_op = (opc == OPC_SKIP_BIT) || (opc == OPC_BIT_WR);
    endfunction

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_EXTRA = 2'b10
    } icfu_state_e;

    icfu_state_e state_ff;
    logic        take;
    logic        reject;
    logic        skip_go;
    logic        two;
    logic        skip_pend_ff;

    assign take    = instr_valid && instr_ready_ff;
    // Out-of-window bit access is refused and behaves as a one-cycle no-op
    assign reject  = is_bit_op(instr.opc) && instr.mem_target
                     && (instr.addr > BIT_ADDR_MAX);                     // [RQ8]
    assign skip_go = instr.skip_met && !reject
                     && (instr.opc == OPC_SKIP_CMP || instr.opc == OPC_SKIP_BIT);
    assign two     = (instr.opc == OPC_BRANCH) || (instr.opc == OPC_INT_EXIT)  // [RQ1]
                     || skip_go;                                          // [RQ2] [RQ3] [RQ4]

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff       <= ST_IDLE;
            instr_ready_ff <= 1'b1;
            skip_pend_ff   <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (take && two) begin
                        state_ff       <= ST_EXTRA;
                        instr_ready_ff <= 1'b0;
                        skip_pend_ff   <= skip_go;
                    end
                end
                ST_EXTRA: begin
                    state_ff       <= ST_IDLE;
                    instr_ready_ff <= 1'b1;
                    skip_pend_ff   <= 1'b0;
                end
                default: begin
                    state_ff       <= ST_IDLE;
                    instr_ready_ff <= 1'b1;
                    skip_pend_ff   <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    // Flags are written in the first cycle; a second cycle never writes them
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_ff <= '0;
        end else begin
            status_ff.flag_we    <= take ? (reject ? FMASK_NONE : flag_mask(instr.opc))
                                         : FMASK_NONE;
            status_ff.bit_reject <= take && reject;                      // [RQ8]
            status_ff.done       <= (take && !two) || (state_ff == ST_EXTRA);  // [RQ3] [RQ4]
            status_ff.two_cycle  <= (state_ff == ST_EXTRA);              // [RQ1] [RQ2]
            status_ff.discard    <= (state_ff == ST_EXTRA) && skip_pend_ff; // [RQ11]
        end
    end

    // ************************************************************
    // Global interrupt enable
    // ************************************************************
    // Entry wins over a simultaneous exit so a new handler is never reentered
    always_ff @(posedge mclk) begin
        if (rst) begin
            gie_ff <= 1'b0;
        end else if (irq_entry) begin
            gie_ff <= 1'b0;                                              // [RQ10]
        end else if (take && (instr.opc == OPC_INT_EXIT || instr.opc == OPC_GIE_ON)) begin
            gie_ff <= 1'b1;                                              // [RQ9]
        end else if (take && instr.opc == OPC_GIE_OFF) begin
            gie_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_branch_two_cyc: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
        take && instr.opc == OPC_BRANCH |=> !instr_ready_ff ##1 status_ff.done
            && status_ff.two_cycle)
        else $error("branch did not take two cycles");

    a_skip_met_two: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
        take && instr.opc == OPC_SKIP_CMP && instr.skip_met |=> ##1 status_ff.discard)
        else $error("met skip did not discard next");

    a_skip_unmet_one: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
        take && instr.opc == OPC_SKIP_CMP && !instr.skip_met
            |=> status_ff.done && instr_ready_ff && !status_ff.two_cycle)
        else $error("unmet skip not single cycle");

    a_other_one_cyc: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
        take && instr.opc == OPC_ARITH |=> status_ff.done && instr_ready_ff)
        else $error("plain instruction not single cycle");

    a_arith_all_flags: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
        take && instr.opc == OPC_ARITH |=> status_ff.flag_we == 4'hf)
        else $error("arith did not write all flags");

    a_logic_zero_only: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
        take && instr.opc == OPC_LOGIC_Z |=> status_ff.flag_we == FMASK_Z)
        else $error("logic flag mask wrong");

    a_xor_io_none: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
        take && instr.opc == OPC_XOR_IO |=> status_ff.flag_we == FMASK_NONE)
        else $error("io xor wrote flags");

    a_carry_only: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
        take && instr.opc == OPC_CARRY |=> status_ff.flag_we == 4'h2)
        else $error("shift flag mask wrong");

    a_bit_window: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
        take && instr.opc == OPC_BIT_WR && instr.mem_target && instr.addr > 8'h3f
            |=> status_ff.bit_reject && status_ff.done)
        else $error("bit access above window not refused");

    a_exit_sets_gie: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
        take && instr.opc == OPC_INT_EXIT && !irq_entry |=> gie_ff)
        else $error("interrupt exit left enable clear");

    a_entry_clrs_gie: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
        irq_entry |=> !gie_ff)
        else $error("interrupt entry left enable set");

    a_discard_noflag: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
        status_ff.discard |-> status_ff.flag_we == 4'h0 && status_ff.done)
        else $error("discarded slot wrote flags");

    // Remaining classes, so that every decoded code has a check behind it
    a_restore_all: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
        take && instr.opc == OPC_RESTORE |=> status_ff.flag_we == FMASK_ALL)
        else $error("restore did not reload all flags");

    a_skip_cmp_flags: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
        take && instr.opc == OPC_SKIP_CMP |=> status_ff.flag_we == FMASK_ALL)
        else $error("compare skip did not write all flags");

    a_quiet_classes: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
        take && (instr.opc inside {OPC_PLAIN, OPC_BRANCH, OPC_INT_EXIT, OPC_BIT_WR,
                                   OPC_SKIP_BIT, OPC_GIE_ON, OPC_GIE_OFF})
            |=> status_ff.flag_we == FMASK_NONE)
        else $error("flagless instruction wrote flags");

    a_exit_two_cyc: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
        take && instr.opc == OPC_INT_EXIT |=> !instr_ready_ff ##1 status_ff.done
            && status_ff.two_cycle)
        else $error("interrupt exit did not take two cycles");

    // Ready is low for one cycle only, so a stalled fetch cannot hang
    a_ready_one_low: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
        !instr_ready_ff |=> instr_ready_ff)
        else $error("ready held low too long");

    a_bit_skip_two: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
        take && instr.opc == OPC_SKIP_BIT && instr.skip_met
            && !(instr.mem_target && instr.addr > BIT_ADDR_MAX)
            |=> !instr_ready_ff ##1 status_ff.discard && status_ff.two_cycle)
        else $error("met bit skip did not take two cycles");

    a_bit_unmet_one: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
        take && instr.opc == OPC_SKIP_BIT && !instr.skip_met
            |=> status_ff.done && instr_ready_ff && !status_ff.two_cycle)
        else $error("unmet bit skip not single cycle");

    // A refused bit skip must not leave a discard behind it
    a_bit_skip_refused: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
        take && instr.opc == OPC_SKIP_BIT && instr.mem_target && instr.addr > BIT_ADDR_MAX
            |=> status_ff.bit_reject && status_ff.done && instr_ready_ff ##1 !status_ff.discard)
        else $error("bit skip above window not refused");

    a_io_bit_kept: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
        take && (instr.opc == OPC_SKIP_BIT || instr.opc == OPC_BIT_WR) && !instr.mem_target
            |=> !status_ff.bit_reject)
        else $error("io bit access refused");

    a_discard_in_extra: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
        status_ff.discard |-> status_ff.two_cycle && instr_ready_ff)
        else $error("discard outside second cycle");

endmodule

// [verilog/icfu_pkg.sv]
// Constants, opcode classes and carriers for the cycle and flag controller.
// Assumes the fetch stage classifies each instruction before handing it over.
//
// Behaviour
// (RQ1) Jumps, calls, indirect moves, returns take two cycles
// (RQ2) Conditional skips take two cycles when met
// (RQ3) Unmet skip completes in one cycle
// (RQ4) All other instructions take one cycle
// (RQ5) Arithmetic, compares and counting skips update all flags
// (RQ6) Logic, negate, memory loads update zero only; the code writes no flags for the logic class OPC_XOR_IO
// (RQ7) Shifts carry only; restore all; others none
// (RQ8) Bit access to memory only below 0x40
// (RQ9) Interrupt exit sets global interrupt enable
// (RQ10) Interrupt entry clears global interrupt enable
// (RQ11) Skip cycle discards next instruction, no flags
package icfu_pkg;

    // ************************************************************
    // Flag write mask positions
    // ************************************************************
    localparam int          FLAG_Z   = 0;
    localparam int          FLAG_C   = 1;
    localparam int          FLAG_AC  = 2;
    localparam int          FLAG_OV  = 3;
    localparam logic [3:0]  FMASK_NONE = 4'h0;
    localparam logic [3:0]  FMASK_ALL  = 4'hf;
    localparam logic [3:0]  FMASK_Z    = 4'h1;
    localparam logic [3:0]  FMASK_C    = 4'h2;

    // ************************************************************
    // Memory window for bit-granular access
    // ************************************************************
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  BIT_ADDR_MAX = 8'h3f;

    // ************************************************************
    // Instruction classes
    // ************************************************************
    typedef enum logic [3:0] {
        OPC_PLAIN     = 4'h0,  // moves, clear, swap, nop, system
        OPC_BRANCH    = 4'h1,  // goto, call, indirect move, pc add, ret
        OPC_INT_EXIT  = 4'h2,
        OPC_SKIP_CMP  = 4'h3,  // compare and count skips
        OPC_SKIP_BIT  = 4'h4,  // test_low_skip / test_high_skip
        OPC_ARITH     = 4'h5,
        OPC_LOGIC_Z   = 4'h6,  // logic, not, negate, loads to acc
        OPC_XOR_IO    = 4'h7,
        OPC_CARRY     = 4'h8,  // shift_right, shift_left, rotates, exchange
        OPC_RESTORE   = 4'h9,
        OPC_BIT_WR    = 4'ha,  // bit_set_op / bit_clear_op
        OPC_GIE_ON    = 4'hb,
        OPC_GIE_OFF   = 4'hc
    } icfu_opc_e;

    typedef struct packed {
        icfu_opc_e          opc;
        logic               mem_target;  // operand is data memory, not IO
        logic [ADDR_W-1:0]  addr;
        logic               skip_met;    // skip condition from the ALU
    } icfu_instr_s;

    typedef struct packed {
        logic               done;        // instruction completed
        logic               two_cycle;   // it took two cycles
        logic               discard;     // next fetch is dropped
        logic [3:0]         flag_we;
        logic               bit_reject;  // bit access outside window
    } icfu_status_s;

endpackage

// [sim/icfu_ctrl_bench.sv]
// Self-checking bench for the cycle and flag controller.
// Assumes the bench alone plays the fetch stage and the interrupt logic.
`timescale 1ns/1ps

module icfu_ctrl_bench import icfu_pkg::*;;
    logic          mclk;
    logic          rst;
    logic          instr_valid;
    icfu_instr_s   instr;
    logic          irq_entry;
    logic          instr_ready_ff;
    icfu_status_s  status_ff;
    logic          gie_ff;
    int            n_mismatch;
    int            n_compared;
    int            cyc;

    icfu_ctrl DUT (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .irq_entry(irq_entry), .instr_ready_ff(instr_ready_ff), .status_ff(status_ff),
        .gie_ff(gie_ff));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc > 2000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ************************************************************
    // One transfer
    // ************************************************************
    // Valid stays up through the second cycle so a refused offer is exercised
    task automatic run(input icfu_opc_e o, input logic mt, input logic [7:0] a,
                       input logic s, input logic two, input logic [3:0] msk,
                       input logic dis, input logic rej);
        instr_valid = 1'b1;
        instr = '{opc: o, mem_target: mt, addr: a, skip_met: s};
        @(posedge mclk) #5;
        chk(status_ff.flag_we === msk && status_ff.bit_reject === rej, "flag mask");
        chk(status_ff.done === !two && instr_ready_ff === !two, "first cycle");
        if (two) begin
            @(posedge mclk) #5;
            chk(status_ff.done === 1'b1 && status_ff.two_cycle === 1'b1, "second cycle");
            chk(status_ff.discard === dis && status_ff.flag_we === 4'h0, "discard slot");
            chk(instr_ready_ff === 1'b1 && status_ff.bit_reject === 1'b0, "ready again");
        end else begin
            chk(status_ff.two_cycle === 1'b0 && status_ff.discard === 1'b0, "one cycle");
        end
    endtask

    task automatic idle();
        instr_valid = 1'b0;
        @(posedge mclk) #5;
        chk(status_ff.done === 1'b0 && status_ff.flag_we === 4'h0, "idle quiet");
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_classes();
        run(OPC_BRANCH, 1'b0, 8'h00, 1'b0, 1'b1, FMASK_NONE, 1'b0, 1'b0);
        run(OPC_ARITH, 1'b1, 8'h10, 1'b0, 1'b0, FMASK_ALL, 1'b0, 1'b0);
        run(OPC_LOGIC_Z, 1'b1, 8'h80, 1'b0, 1'b0, FMASK_Z, 1'b0, 1'b0);
        run(OPC_XOR_IO, 1'b0, 8'h05, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        run(OPC_CARRY, 1'b1, 8'h20, 1'b0, 1'b0, FMASK_C, 1'b0, 1'b0);
        run(OPC_RESTORE, 1'b0, 8'h00, 1'b0, 1'b0, FMASK_ALL, 1'b0, 1'b0);
        run(OPC_PLAIN, 1'b1, 8'h90, 1'b1, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        run(OPC_BIT_WR, 1'b1, 8'h01, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        run(OPC_GIE_OFF, 1'b0, 8'h00, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        idle();
    endtask

    task automatic t_skips();
        run(OPC_SKIP_CMP, 1'b1, 8'h50, 1'b1, 1'b1, FMASK_ALL, 1'b1, 1'b0);
        run(OPC_SKIP_CMP, 1'b1, 8'h50, 1'b0, 1'b0, FMASK_ALL, 1'b0, 1'b0);
        run(OPC_SKIP_BIT, 1'b1, 8'h3f, 1'b1, 1'b1, FMASK_NONE, 1'b1, 1'b0);
        run(OPC_SKIP_BIT, 1'b0, 8'hff, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        idle();
    endtask

    // First address past the window, with a met skip that must not be taken
    task automatic t_window();
        run(OPC_SKIP_BIT, 1'b1, 8'h40, 1'b1, 1'b0, FMASK_NONE, 1'b0, 1'b1);
        run(OPC_BIT_WR, 1'b1, 8'hff, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b1);
        run(OPC_BIT_WR, 1'b0, 8'hff, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        idle();
    endtask

    task automatic t_gie();
        run(OPC_GIE_ON, 1'b0, 8'h00, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        idle();
        chk(gie_ff === 1'b1, "enable on");
        irq_entry = 1'b1;
        @(posedge mclk) #5;
        irq_entry = 1'b0;
        @(posedge mclk) #5;
        chk(gie_ff === 1'b0, "entry clears enable");
        run(OPC_INT_EXIT, 1'b0, 8'h00, 1'b0, 1'b1, FMASK_NONE, 1'b0, 1'b0);
        idle();
        chk(gie_ff === 1'b1, "exit sets enable");
    endtask

    // Disable clears the enable; an entry on the exit's take edge must win
    task automatic t_gie_race();
        run(OPC_GIE_OFF, 1'b0, 8'h00, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        chk(gie_ff === 1'b0, "disable clears enable");
        instr = '{opc: OPC_INT_EXIT, mem_target: 1'b0, addr: 8'h00, skip_met: 1'b0};
        irq_entry = 1'b1;
        @(posedge mclk) #5;
        irq_entry = 1'b0;
        chk(gie_ff === 1'b0 && instr_ready_ff === 1'b0, "entry beats exit");
        @(posedge mclk) #5;
        chk(gie_ff === 1'b0 && status_ff.two_cycle === 1'b1, "no late enable");
        idle();
    endtask

    // Reset in the middle of a met skip drops the pending discard
    task automatic t_reset();
        run(OPC_GIE_ON, 1'b0, 8'h00, 1'b0, 1'b0, FMASK_NONE, 1'b0, 1'b0);
        instr = '{opc: OPC_SKIP_CMP, mem_target: 1'b1, addr: 8'h20, skip_met: 1'b1};
        @(posedge mclk) #5;
        chk(instr_ready_ff === 1'b0 && gie_ff === 1'b1, "skip in progress");
        rst = 1'b1;
        instr_valid = 1'b0;
        @(posedge mclk) #5;
        chk(instr_ready_ff === 1'b1 && status_ff === '0 && gie_ff === 1'b0, "mid-run reset");
        rst = 1'b0;
        run(OPC_ARITH, 1'b1, 8'h10, 1'b0, 1'b0, FMASK_ALL, 1'b0, 1'b0);
        idle();
    endtask

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        cyc = 0;
        rst = 1'b1;
        instr_valid = 1'b0;
        irq_entry = 1'b0;
        instr = '{opc: OPC_PLAIN, mem_target: 1'b0, addr: 8'h00, skip_met: 1'b0};
        repeat (3) @(posedge mclk);
        #5;
        rst = 1'b0;
        chk(instr_ready_ff === 1'b1 && status_ff === '0 && gie_ff === 1'b0, "reset state");
        t_classes();
        t_skips();
        t_window();
        t_gie();
        t_gie_race();
        t_reset();
        finish_test();
    end
endmodule
